// >>> hw/apd_power_ctrl.v
// apd_power_ctrl.v: power-down sequencing of a serial converter
// assumes every pin input is asynchronous to CLK_IN and is synchronised here;
// the serial clock is sampled as a plain input and its edges found by the clock
`timescale 1ns/1ps
`include "apd_map.vh"

// How it works
// - enter auto low power after each conversion
// - reference stays on in auto low power
// - wake from auto low power within three clocks
// - select, frame sync or start strobe wakes
// - command word 8000h enters full software power-down
// - power-down pin forces full power-down at the next clock edge
// - external reference: no wait after software wake
// - hardware power-down ends only on pin release
// - configuration kept through every power-down
// - sweep restarts at first entry after power-down
// - every power-down empties the result fifo
// - out-of-range inputs clamp to all ones/zeros
// - configuration write raises no end-of-conversion, no conversion
module apd_power_ctrl #(
  parameter WARM_CYC = `APD_WARM_CYC    // reference warm-up count in clocks
) (
  // clock and reset
  input  wire                   CLK_IN,
  input  wire                   NRST_IN,
  // serial interface pins
  input  wire                   CS_N_IN,
  input  wire                   FRAME_SYNC_STROBE_IN,
  input  wire                   CONVERSION_START_STROBE_N_IN,
  input  wire                   SCLK_IN,
  input  wire                   SDI_IN,
  // power-down pin
  input  wire                   POWER_DOWN_PIN_N_IN,
  // converter core events and settings
  input  wire                   CONV_DONE_IN,
  input  wire                   CFG_WRITE_IN,
  input  wire [`APD_CFG_W-1:0]  CFG_DATA_IN,
  input  wire                   INT_REF_SEL_IN,
  input  wire                   FIFO_PUSH_IN,
  input  wire                   SWEEP_STEP_IN,
  input  wire                   ABOVE_UPPER_REFERENCE_IN,
  input  wire                   BELOW_LOWER_REFERENCE_IN,
  input  wire [`APD_CODE_W-1:0] RAW_CODE_IN,
  // power state outputs
  output reg                    CORE_ON_OUT,
  output reg                    REF_ON_OUT,
  output reg                    SW_POWER_DOWN_PIN_N_OUT,
  output reg                    HW_POWER_DOWN_PIN_N_OUT,
  output reg                    REF_READY_OUT,
  // data path outputs
  output reg  [`APD_CFG_W-1:0]  CFG_OUT,
  output reg  [`APD_FILL_W-1:0] FIFO_FILL_OUT,
  output reg  [`APD_SWEEP_W-1:0] SWEEP_POS_OUT,
  output reg  [`APD_CODE_W-1:0] CODE_OUT,
  output reg                    EOC_OUT
);

  // power states, one-hot
  localparam [3:0] ST_ACTIVE = 4'b0001;   // converting or serving a cycle
  localparam [3:0] ST_AUTO   = 4'b0010;   // auto low power, reference on
  localparam [3:0] ST_SW     = 4'b0100;   // software power-down
  localparam [3:0] ST_HW     = 4'b1000;   // hardware power-down

  // synchroniser stages: first stage read only by second
  reg [4:0] s1_q;                         // first stage of all pins but the power-down pin
  reg [4:0] s2_q;                         // second stage, safe to use
  reg       sclk_d1_q;                    // previous synchronised serial clock
  reg       wake_q;                       // wake strobes one clock ago
  reg       power_down_pin_n_n_a1_q;                  // async-clear power-down sync, stage 1
  reg       power_down_pin_n_n_a2_q;                  // async-clear power-down sync, stage 2

  wire cs_n   = s2_q[0];                  // chip select, active low
  wire fs     = s2_q[1];                  // frame sync, active high
  wire cst_n  = s2_q[2];                  // conversion start, active low
  wire sclk   = s2_q[3];                  // serial clock level
  wire sdi    = s2_q[4];                  // serial data level

  // shift register and state
  reg [`APD_WORD_BITS-1:0] shift_q;       // incoming command word
  reg [`APD_CNT_W-1:0]     bits_q;        // bits taken in this frame
  reg [3:0]                st_q;          // power state
  reg [3:0]                st_d;          // next power state
  reg [31:0]               warm_q;        // warm-up countdown

  wire sclk_rise = sclk & ~sclk_d1_q;     // serial clock rising edge
  wire wake      = ~cs_n | fs | ~cst_n;   // any wake strobe active
  wire wake_rise = wake & ~wake_q;        // a fresh strobe, not one left held
  wire word_done = sclk_rise & (bits_q == `APD_LAST_BIT);
  wire [`APD_WORD_BITS-1:0] word_full = {shift_q[`APD_WORD_BITS-2:0], sdi};
  wire sw_cmd    = word_done & (word_full == `APD_CMD_SW_POWER_DOWN_PIN_N);
  wire any_pd    = st_q[2] | st_q[3];     // a full power-down is in force
  wire hw_pd     = ~power_down_pin_n_n_a2_q;

  // clamp an out-of-range sample to the rail codes
  function [`APD_CODE_W-1:0] clamp_code;
    input                   above;
    input                   below;
    input [`APD_CODE_W-1:0] raw;
    begin
      if (above) begin
        clamp_code = `APD_CODE_ONES;
      end else if (below) begin
        clamp_code = `APD_CODE_ZERO;
      end else begin
        clamp_code = raw;
      end
    end
  endfunction

  // two-flop sync of the ordinary pins
  always @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      s1_q      <= 5'h05;                 // idle: cs high, frame sync low, start high
      s2_q      <= 5'h05;
      sclk_d1_q <= 1'b0;
      wake_q    <= 1'b0;                  // idle pins give no wake
    end else begin
      s1_q      <= {SDI_IN, SCLK_IN, CONVERSION_START_STROBE_N_IN,
                    FRAME_SYNC_STROBE_IN, CS_N_IN};
      s2_q      <= s1_q;
      sclk_d1_q <= sclk;
      wake_q    <= wake;
    end
  end

  // power-down pin: asserting clears the sync at once, release passes two flops
  always @(posedge CLK_IN or negedge POWER_DOWN_PIN_N_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      power_down_pin_n_n_a1_q <= 1'b1;
      power_down_pin_n_n_a2_q <= 1'b1;
    end else if (!POWER_DOWN_PIN_N_IN) begin
      power_down_pin_n_n_a1_q <= 1'b0;
      power_down_pin_n_n_a2_q <= 1'b0;
    end else begin
      power_down_pin_n_n_a1_q <= 1'b1;
      power_down_pin_n_n_a2_q <= power_down_pin_n_n_a1_q;
    end
  end

  // command word shifter, msb first, framed by chip select or frame sync
  always @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      shift_q <= {`APD_WORD_BITS{1'b0}};
      bits_q  <= {`APD_CNT_W{1'b0}};
    end else if (cs_n || fs || hw_pd) begin
      bits_q  <= {`APD_CNT_W{1'b0}};     // frame restarts
    end else if (sclk_rise) begin
      shift_q <= word_full;
      if (word_done) begin
        bits_q <= {`APD_CNT_W{1'b0}};
      end else begin
        bits_q <= bits_q + 1'b1;
      end
    end
  end

  // next power state
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_ACTIVE: begin
        if (sw_cmd) begin
          st_d = ST_SW;
        end else if (CONV_DONE_IN && !CFG_WRITE_IN) begin
          st_d = ST_AUTO;                 // a write is no conversion
        end
      end
      ST_AUTO: begin
        if (wake) begin
          st_d = ST_ACTIVE;
        end
      end
      ST_SW: begin
        // the select still held low after the command must not undo it
        if (wake_rise) begin
          st_d = ST_ACTIVE;
        end
      end
      ST_HW: begin
        st_d = ST_AUTO;                   // pin released
      end
      default: begin
        st_d = ST_AUTO;
      end
    endcase
    if (hw_pd) begin
      st_d = ST_HW;                       // pin overrides all
    end
  end

  // state, warm-up count and power outputs
  always @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      st_q          <= ST_AUTO;
      warm_q        <= 32'h0;
      CORE_ON_OUT   <= 1'b0;
      REF_ON_OUT    <= 1'b1;
      SW_POWER_DOWN_PIN_N_OUT   <= 1'b0;
      HW_POWER_DOWN_PIN_N_OUT   <= 1'b0;
      REF_READY_OUT <= 1'b1;
    end else begin
      st_q          <= st_d;
      CORE_ON_OUT   <= st_d[0];
      REF_ON_OUT    <= st_d[0] | st_d[1];
      SW_POWER_DOWN_PIN_N_OUT   <= st_d[2];
      HW_POWER_DOWN_PIN_N_OUT   <= st_d[3];
      // warm-up only with the internal reference coming back
      if (st_d[2] || st_d[3]) begin
        warm_q        <= 32'h0;
        REF_READY_OUT <= 1'b0;
      end else if (any_pd) begin
        warm_q        <= INT_REF_SEL_IN ? WARM_CYC : 32'h0;
        REF_READY_OUT <= ~INT_REF_SEL_IN;
      end else if (warm_q > 32'h1) begin
        warm_q        <= warm_q - 32'h1;
      end else begin
        warm_q        <= 32'h0;
        REF_READY_OUT <= 1'b1;
      end
    end
  end

  // configuration, fifo level, sweep, result code and end-of-conversion
  always @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      CFG_OUT       <= `APD_CFG_RST;
      FIFO_FILL_OUT <= {`APD_FILL_W{1'b0}};
      SWEEP_POS_OUT <= {`APD_SWEEP_W{1'b0}};
      CODE_OUT      <= `APD_CODE_ZERO;
      EOC_OUT       <= 1'b0;
    end else begin
      if (CFG_WRITE_IN) begin
        CFG_OUT <= CFG_DATA_IN;           // untouched by power-down
      end
      // end-of-conversion only from a real conversion
      EOC_OUT <= CONV_DONE_IN & ~CFG_WRITE_IN & st_q[0];
      if (CONV_DONE_IN && !CFG_WRITE_IN && st_q[0]) begin
        CODE_OUT <= clamp_code(ABOVE_UPPER_REFERENCE_IN,
                               BELOW_LOWER_REFERENCE_IN, RAW_CODE_IN);
      end
      if (st_d[2] || st_d[3]) begin
        FIFO_FILL_OUT <= {`APD_FILL_W{1'b0}};
        SWEEP_POS_OUT <= {`APD_SWEEP_W{1'b0}};
      end else begin
        if (FIFO_PUSH_IN && FIFO_FILL_OUT != 4'h8) begin
          FIFO_FILL_OUT <= FIFO_FILL_OUT + 1'b1;
        end
        if (SWEEP_STEP_IN) begin
          SWEEP_POS_OUT <= SWEEP_POS_OUT + 1'b1;
        end
      end
    end
  end

endmodule

// >>> hw/apd_map.vh
// apd_map.vh: constants for the converter power-down control block
// assumes inclusion by the design file and the dv files; definitions only
`ifndef APD_MAP_VH
`define APD_MAP_VH

// command word that enters software power-down
`define APD_CMD_SW_POWER_DOWN_PIN_N     16'h8000
// serial word length in bits
`define APD_WORD_BITS       16
// bit count width
`define APD_CNT_W           5
// bit count value at the last bit of a word
`define APD_LAST_BIT        5'h0f
// result code width
`define APD_CODE_W          12
// all-zeros and all-ones result codes
`define APD_CODE_ZERO       12'h000
`define APD_CODE_ONES       12'hfff
// fifo fill level width (eight entries)
`define APD_FILL_W          4
// sweep position width
`define APD_SWEEP_W         3
// configuration word width and reset value
`define APD_CFG_W           12
`define APD_CFG_RST         12'h000
// reference warm-up time in ms, and cycles at the 125 MHz clock
`define APD_WARM_MS         20
`define APD_CLK_MHZ         125
`define APD_WARM_CYC        (`APD_WARM_MS * 1000 * `APD_CLK_MHZ)

`endif

// >>> dv/apd_host.sv
// apd_host.sv: host serial port model for the power-down block
// assumes the bench calls its tasks; link clock parked low between frames
`timescale 1ns/1ps
module apd_host (
  // serial pins toward the converter
  output logic cs_n_out,
  output logic fs_out,
  output logic start_n_out,
  output logic sclk_out,
  output logic sdi_out
);
  // idle: deselected, strobes off, clock still
  initial begin
    cs_n_out    = 1'b1;
    fs_out      = 1'b0;
    start_n_out = 1'b1;
    sclk_out    = 1'b0;
    sdi_out     = 1'b0;
  end
  // one 16-bit word, msb first, 125 ns clock
  task send(input logic [15:0] w);
    cs_n_out = 1'b0;
    #62.5;
    for (int i = 15; i >= 0; i--) begin
      sdi_out = w[i];
      #62.5 sclk_out = 1'b1;
      #62.5 sclk_out = 1'b0;
    end
    // released data line must not keep its last value
    sdi_out = ~sdi_out;
    #62.5 cs_n_out = 1'b1;
  endtask
  // wake strobe: 0 select, 1 frame sync, 2 start
  task strobe(input int k);
    if (k == 0) cs_n_out = 1'b0;
    else if (k == 1) fs_out = 1'b1;
    else start_n_out = 1'b0;
    #100;
    cs_n_out    = 1'b1;
    fs_out      = 1'b0;
    start_n_out = 1'b1;
  endtask
endmodule

// >>> dv/apd_props.sv
// apd_props.sv: port assertions for the power-down block
// assumes binding to apd_power_ctrl; one clock domain
`timescale 1ns/1ps
`include "apd_map.vh"
module apd_props #(parameter WARM_CYC = 50) (
  input wire                    CLK_IN,
  input wire                    NRST_IN,
  input wire                    CS_N_IN,
  input wire                    POWER_DOWN_PIN_N_IN,
  input wire                    CONV_DONE_IN,
  input wire                    CFG_WRITE_IN,
  input wire                    INT_REF_SEL_IN,
  input wire                    ABOVE_UPPER_REFERENCE_IN,
  input wire                    BELOW_LOWER_REFERENCE_IN,
  input wire                    CORE_ON_OUT,
  input wire                    REF_ON_OUT,
  input wire                    SW_POWER_DOWN_PIN_N_OUT,
  input wire                    HW_POWER_DOWN_PIN_N_OUT,
  input wire                    REF_READY_OUT,
  input wire [`APD_CFG_W-1:0]   CFG_OUT,
  input wire [`APD_FILL_W-1:0]  FIFO_FILL_OUT,
  input wire [`APD_SWEEP_W-1:0] SWEEP_POS_OUT,
  input wire [`APD_CODE_W-1:0]  CODE_OUT,
  input wire                    EOC_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);
  eoc_cause_a: assert property (
    EOC_OUT |-> $past(CONV_DONE_IN) && !$past(CFG_WRITE_IN))
    else $error("end of conversion without a conversion");
  auto_after_conv_a: assert property (
    EOC_OUT |-> !CORE_ON_OUT && REF_ON_OUT)
    else $error("not in auto low power after conversion");
  clamp_high_a: assert property (
    EOC_OUT && $past(ABOVE_UPPER_REFERENCE_IN) |-> CODE_OUT == 12'hfff)
    else $error("high input not all ones");
  clamp_low_a: assert property (
    EOC_OUT && $past(BELOW_LOWER_REFERENCE_IN) && !$past(ABOVE_UPPER_REFERENCE_IN)
    |-> CODE_OUT == 12'h000)
    else $error("low input not all zeros");
  hw_enter_a: assert property (
    !POWER_DOWN_PIN_N_IN [*2] |-> HW_POWER_DOWN_PIN_N_OUT && !REF_ON_OUT)
    else $error("pin low but no hardware power-down");
  hw_hold_a: assert property (
    HW_POWER_DOWN_PIN_N_OUT && !POWER_DOWN_PIN_N_IN |=> HW_POWER_DOWN_PIN_N_OUT)
    else $error("hardware power-down left with pin low");
  power_down_pin_n_clear_a: assert property (
    $rose(SW_POWER_DOWN_PIN_N_OUT) || $rose(HW_POWER_DOWN_PIN_N_OUT) |-> FIFO_FILL_OUT == 0 && SWEEP_POS_OUT == 0)
    else $error("fifo or sweep kept through power-down");
  cfg_keep_a: assert property (
    (SW_POWER_DOWN_PIN_N_OUT || HW_POWER_DOWN_PIN_N_OUT) && !CFG_WRITE_IN |=> $stable(CFG_OUT))
    else $error("config changed in power-down");
  sw_off_a: assert property (
    SW_POWER_DOWN_PIN_N_OUT |-> !REF_ON_OUT && !CORE_ON_OUT && !REF_READY_OUT)
    else $error("software power-down left something on");
  select_wake_a: assert property (
    $fell(CS_N_IN) && POWER_DOWN_PIN_N_IN && !HW_POWER_DOWN_PIN_N_OUT |-> ##[1:5] CORE_ON_OUT)
    else $error("select did not wake");
  ext_ready_a: assert property (
    $fell(SW_POWER_DOWN_PIN_N_OUT) && !HW_POWER_DOWN_PIN_N_OUT && !$past(INT_REF_SEL_IN) |-> REF_READY_OUT)
    else $error("reference not ready after wake with external reference");
  warm_start_a: assert property (
    $fell(HW_POWER_DOWN_PIN_N_OUT) && $past(INT_REF_SEL_IN) |-> !REF_READY_OUT)
    else $error("internal reference ready without warm-up");
  // main scenarios reached
  conv_c: cover property (EOC_OUT);
  sw_c: cover property ($rose(SW_POWER_DOWN_PIN_N_OUT));
  hw_c: cover property ($rose(HW_POWER_DOWN_PIN_N_OUT));
endmodule
bind apd_power_ctrl apd_props #(.WARM_CYC(WARM_CYC)) u_apd_props (.CLK_IN, .NRST_IN, .CS_N_IN,
  .POWER_DOWN_PIN_N_IN, .CONV_DONE_IN, .CFG_WRITE_IN, .INT_REF_SEL_IN, .ABOVE_UPPER_REFERENCE_IN,
  .BELOW_LOWER_REFERENCE_IN, .CORE_ON_OUT, .REF_ON_OUT, .SW_POWER_DOWN_PIN_N_OUT, .HW_POWER_DOWN_PIN_N_OUT,
  .REF_READY_OUT, .CFG_OUT, .FIFO_FILL_OUT, .SWEEP_POS_OUT, .CODE_OUT, .EOC_OUT);

// >>> dv/apd_tb.sv
// apd_tb.sv: self-checking bench for the power-down block
// assumes apd_host drives the serial pins; warm-up shortened to 50 clocks
`timescale 1ns/1ps
`include "apd_map.vh"
module testbench;
  localparam int WARM = 50;
  logic CLK_IN = 0, NRST_IN = 0, POWER_DOWN_PIN_N_IN = 1, INT_REF_SEL_IN = 0;
  logic CONV_DONE_IN = 0, CFG_WRITE_IN = 0, FIFO_PUSH_IN = 0, SWEEP_STEP_IN = 0;
  logic ABOVE_UPPER_REFERENCE_IN = 0, BELOW_LOWER_REFERENCE_IN = 0;
  logic [11:0] CFG_DATA_IN = 0, RAW_CODE_IN = 0, CFG_OUT, CODE_OUT;
  logic [3:0] FIFO_FILL_OUT;
  logic [2:0] SWEEP_POS_OUT;
  logic CORE_ON_OUT, REF_ON_OUT, SW_POWER_DOWN_PIN_N_OUT, HW_POWER_DOWN_PIN_N_OUT, REF_READY_OUT, EOC_OUT;
  wire CS_N_IN, FRAME_SYNC_STROBE_IN, CONVERSION_START_STROBE_N_IN, SCLK_IN, SDI_IN;
  int err_count = 0, checks = 0;
  always #4 CLK_IN = ~CLK_IN;
  apd_host u_apd_host (.cs_n_out(CS_N_IN), .fs_out(FRAME_SYNC_STROBE_IN),
    .start_n_out(CONVERSION_START_STROBE_N_IN), .sclk_out(SCLK_IN), .sdi_out(SDI_IN));
  apd_power_ctrl #(.WARM_CYC(WARM)) u_apd_power_ctrl (.CLK_IN, .NRST_IN, .CS_N_IN,
    .FRAME_SYNC_STROBE_IN, .CONVERSION_START_STROBE_N_IN, .SCLK_IN, .SDI_IN,
    .POWER_DOWN_PIN_N_IN, .CONV_DONE_IN, .CFG_WRITE_IN, .CFG_DATA_IN, .INT_REF_SEL_IN,
    .FIFO_PUSH_IN, .SWEEP_STEP_IN, .ABOVE_UPPER_REFERENCE_IN, .BELOW_LOWER_REFERENCE_IN,
    .RAW_CODE_IN, .CORE_ON_OUT, .REF_ON_OUT, .SW_POWER_DOWN_PIN_N_OUT, .HW_POWER_DOWN_PIN_N_OUT, .REF_READY_OUT,
    .CFG_OUT, .FIFO_FILL_OUT, .SWEEP_POS_OUT, .CODE_OUT, .EOC_OUT);
  // compare one value, zero-extended
  task chk(input string n, input logic [11:0] e, input logic [11:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  // wait n edges, then let updates land
  task cyc(input int n);
    repeat (n) @(posedge CLK_IN);
    #1;
  endtask
  // one-cycle core pulse: bit0 done, 1 cfg write, 2 push, 3 sweep
  task core(input logic [3:0] m);
    @(posedge CLK_IN);
    {SWEEP_STEP_IN, FIFO_PUSH_IN, CFG_WRITE_IN, CONV_DONE_IN} <= m;
    @(posedge CLK_IN);
    {SWEEP_STEP_IN, FIFO_PUSH_IN, CFG_WRITE_IN, CONV_DONE_IN} <= 4'h0;
    #1;
  endtask
  task t_reset;
    cyc(2);
    chk("core", 0, CORE_ON_OUT);
    chk("ref", 1, REF_ON_OUT);
    chk("cfg", 0, CFG_OUT);
    $display("test reset done");
  endtask
  // each strobe wakes; conversion returns to auto with clamped code
  task t_conv;
    for (int k = 0; k < 3; k++) begin
      u_apd_host.strobe(k);
      chk("woken", 1, CORE_ON_OUT);
      @(posedge CLK_IN);
      ABOVE_UPPER_REFERENCE_IN <= (k == 0);
      BELOW_LOWER_REFERENCE_IN <= (k == 1);
      RAW_CODE_IN <= 12'h5a5;
      core(4'h1);
      chk("eoc", 1, EOC_OUT);
      chk("code", k == 0 ? 12'hfff : k == 1 ? 12'h000 : 12'h5a5, CODE_OUT);
      chk("auto core", 0, CORE_ON_OUT);
      chk("auto ref", 1, REF_ON_OUT);
    end
    $display("test conv done");
  endtask
  // config write with done gives no end of conversion
  task t_cfg;
    u_apd_host.strobe(0);
    @(posedge CLK_IN);
    CFG_DATA_IN <= 12'h3c7;
    core(4'h3);
    chk("no eoc", 0, EOC_OUT);
    cyc(1);
    chk("cfg", 12'h3c7, CFG_OUT);
    chk("still on", 1, CORE_ON_OUT);
    $display("test cfg done");
  endtask
  // other word ignored; 8000h powers all down, keeps config
  task t_sw;
    repeat (3) core(4'h4);
    repeat (2) core(4'h8);
    cyc(1);
    chk("fill", 3, FIFO_FILL_OUT);
    chk("sweep", 2, SWEEP_POS_OUT);
    u_apd_host.send(16'h8001);
    cyc(6);
    chk("sw other", 0, SW_POWER_DOWN_PIN_N_OUT);
    u_apd_host.send(16'h8000);
    cyc(6);
    chk("sw", 1, SW_POWER_DOWN_PIN_N_OUT);
    chk("sw ref", 0, REF_ON_OUT);
    chk("sw core", 0, CORE_ON_OUT);
    chk("sw fill", 0, FIFO_FILL_OUT);
    chk("sw sweep", 0, SWEEP_POS_OUT);
    chk("sw cfg", 12'h3c7, CFG_OUT);
    u_apd_host.strobe(0);
    cyc(2);
    chk("sw wake", 0, SW_POWER_DOWN_PIN_N_OUT);
    chk("sw wake core", 1, CORE_ON_OUT);
    chk("ext ready", 1, REF_READY_OUT);
    $display("test sw done");
  endtask
  // pin power-down holds against a frame sync strobe, warm-up after release
  task t_hw;
    @(posedge CLK_IN);
    INT_REF_SEL_IN <= 1'b1;
    core(4'hc);
    chk("hw pre fill", 1, FIFO_FILL_OUT);
    chk("hw pre sweep", 1, SWEEP_POS_OUT);
    @(posedge CLK_IN);
    POWER_DOWN_PIN_N_IN <= 1'b0;
    cyc(2);
    chk("hw", 1, HW_POWER_DOWN_PIN_N_OUT);
    chk("hw ref", 0, REF_ON_OUT);
    chk("hw fill", 0, FIFO_FILL_OUT);
    chk("hw sweep", 0, SWEEP_POS_OUT);
    u_apd_host.strobe(1);
    chk("hw held", 1, HW_POWER_DOWN_PIN_N_OUT);
    @(posedge CLK_IN);
    POWER_DOWN_PIN_N_IN <= 1'b1;
    cyc(5);
    chk("hw exit", 0, HW_POWER_DOWN_PIN_N_OUT);
    chk("warming", 0, REF_READY_OUT);
    cyc(WARM);
    chk("warm", 1, REF_READY_OUT);
    chk("hw cfg", 12'h3c7, CFG_OUT);
    $display("test hw done");
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog: tests need well under 200 us
  initial begin
    #200000;
    err_count++;
    report_and_stop;
  end
  initial begin
    repeat (10) @(posedge CLK_IN);
    NRST_IN <= 1'b1;
    t_reset;
    t_conv;
    t_cfg;
    t_sw;
    t_hw;
    report_and_stop;
  end
endmodule
